//--- hw/cdmf_top.v
/*
 * Mode decoding, modulation and protection control of a two-channel
 * class-D amplifier, with an AXI4-Lite register slave.
 * Assumes straps and fault crossings arrive as clean digital levels
 * synchronous to aclk, and one AXI master with one access at a time.
 */
`timescale 1ns/10ps
`include "cdmf_map.vh"

// What this block does
// [R1] Phase offset only while slave loop enabled.
// [R2] Slave, loop off: pin clock used directly.
// [R3] Decode master/slave and spread/loop straps.
// [R4] Strap mode: six levels give modulation, shift.
// [R5] Host mode: strap picks stereo or parallel.
// [R6] Host mode: modulation, shift from control bits.
// [R7] Latch strap decode when switching starts.
// [R8] Opposed-phase: bridge halves complementary.
// [R9] In-phase: halves together, one input inverted.
// [R10] Slave loop on: offset phase from incoming clock.
// [R11] Host mode: five shifts by three-bit field.
// [R12] Parallel: both stages follow channel one.
// [R13] Host disables clipping on both channels.
// [R14] Foldback level: reduce gain, keep running.
// [R15] Second threshold during foldback: full shutdown.
// [R16] Overtemperature: shut power stage immediately.
// [R17] Current limit without short keeps switching.
// [R18] Short switches off only affected channels outside parallel.
// [R19] Retry shorted channel every 50 ms.
// [R20] Supply short holds channel until removed.
// [R21] Grounded address strap means strap-only control; clip detect enables follow the host control bits in either mode.
// [R22] Restart interval counted in switching periods.
// [R23] Straps and thresholds arrive as digital levels.
module cdmf_top #(
    parameter RESTART_PERIODS = `CDMF_RESTART_PERIODS
) (
    // Clock and synchronous active-low reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address and data
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Decoded straps
    input wire oscillator_resistor_strap,
    input wire spread_loop_strap,
    input wire [2:0] operation_select_strap,
    input wire bus_address_strap,
    // Oscillator clock pin
    input wire oscillator_clock_pin_in,
    output reg oscillator_clock_pin_out,
    output reg oscillator_clock_pin_oe,
    // Amplifier enable and modulator input levels
    input wire amp_enable,
    input wire [4:0] ch1_level,
    input wire [4:0] ch2_level,
    // Protection crossings
    input wire thermal_foldback,
    input wire thermal_trip,
    input wire overtemp,
    input wire [1:0] overcurrent_guard,
    input wire [1:0] load_short,
    input wire [1:0] supply_short,
    // Power stage and status outputs
    output reg [1:0] bridge_p,
    output reg [1:0] bridge_n,
    output reg gain_reduce,
    output reg [1:0] current_limit,
    output reg [1:0] clip_detect_enable,
    output reg switch_clock,
    output reg spread_enable
);

    localparam ST_RUN = 2'h0;
    localparam ST_OFF = 2'h1;
    localparam ST_WIN = 2'h2;

    reg [5:0] ctrl;
    reg [4:0] cnt;
    reg pin_prev;
    reg started;
    reg [2:0] ops_latched;
    wire [2:0] ops_code;
    wire is_master;
    wire loop_on;
    wire host_ctrl;
    wire parallel;
    reg in_phase;
    reg [4:0] offset;
    wire shutdown;
    wire ptick;
    wire pin_rise;
    wire go;
    wire [1:0] ch_run;
    wire [1:0] ch_win;
    wire [4:0] lvl [0:1];
    wire [31:0] status;

    // ==========================================================
    // Strap decoding

    // Oscillator mode from the frequency and loop straps.
    assign is_master = oscillator_resistor_strap; // [R3] [R23]
    assign loop_on = ~oscillator_resistor_strap & spread_loop_strap; // [R3]
    assign host_ctrl = bus_address_strap; // [R21]
    // Once switching has begun the captured strap value is used.
    assign ops_code = started ? ops_latched : operation_select_strap; // [R7]
    assign parallel = host_ctrl & (ops_code == `CDMF_OPS_100K); // [R5]

    // Modulation type and phase offset selection.
    always @* begin
        in_phase = 1'b0;
        offset = `CDMF_OFS_NONE;
        if (host_ctrl) begin
            in_phase = ctrl[`CDMF_CTRL_INPHASE]; // [R6]
            case (ctrl[`CDMF_CTRL_SHIFT_HI:`CDMF_CTRL_SHIFT_LO]) // [R11]
                `CDMF_SEL_QUARTER: offset = `CDMF_OFS_QUARTER;
                `CDMF_SEL_THIRD: offset = `CDMF_OFS_THIRD;
                `CDMF_SEL_HALF: offset = `CDMF_OFS_HALF;
                `CDMF_SEL_TWO_THIRDS: offset = `CDMF_OFS_TWO_THIRDS;
                `CDMF_SEL_THREE_QUARTERS: offset = `CDMF_OFS_THREE_QUARTERS;
                default: offset = `CDMF_OFS_NONE;
            endcase
        end else begin
            case (ops_code) // [R4]
                `CDMF_OPS_4K7: in_phase = 1'b1;
                `CDMF_OPS_13K: offset = `CDMF_OFS_HALF;
                `CDMF_OPS_33K: begin
                    in_phase = 1'b1;
                    offset = `CDMF_OFS_HALF;
                end
                `CDMF_OPS_OPEN: in_phase = 1'b1;
                default: in_phase = 1'b0;
            endcase
        end
        // Staggering needs the slave loop; otherwise no offset at all.
        if (!loop_on) begin
            offset = `CDMF_OFS_NONE; // [R1]
        end
    end

    // ==========================================================
    // Switching phase counter

    // Incoming clock edge and the end-of-period tick.
    assign pin_rise = oscillator_clock_pin_in & ~pin_prev;
    assign ptick = (cnt == 5'h1f);

    // Master runs free; a slave realigns on each incoming rising edge.
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= 5'h00;
            pin_prev <= 1'b0;
        end else begin
            pin_prev <= oscillator_clock_pin_in;
            if (!is_master && pin_rise) begin
                cnt <= offset; // [R10] [R2]
            end else begin
                cnt <= cnt + 5'h01;
            end
        end
    end

    // Clock pin direction and the switching clock seen by the stages.
    always @(posedge aclk) begin
        if (!aresetn) begin
            oscillator_clock_pin_out <= 1'b0;
            oscillator_clock_pin_oe <= 1'b0;
            switch_clock <= 1'b0;
            spread_enable <= 1'b0;
        end else begin
            oscillator_clock_pin_out <= ~cnt[4];
            oscillator_clock_pin_oe <= is_master; // [R3]
            spread_enable <= is_master & spread_loop_strap; // [R3]
            if (!is_master && !loop_on) begin
                switch_clock <= oscillator_clock_pin_in; // [R2]
            end else begin
                switch_clock <= ~cnt[4];
            end
        end
    end

    // ==========================================================
    // Start of switching and strap capture

    // Full shutdown from overtemperature or the second thermal level.
    assign shutdown = overtemp | (thermal_foldback & thermal_trip); // [R15] [R16]
    assign go = amp_enable & ~shutdown;

    // The strap value is captured in the cycle switching starts.
    always @(posedge aclk) begin
        if (!aresetn) begin
            started <= 1'b0;
            ops_latched <= `CDMF_OPS_SHORT;
        end else if (!amp_enable) begin
            started <= 1'b0;
        end else if (go && !started && (ch_run != 2'b00)) begin
            started <= 1'b1;
            ops_latched <= operation_select_strap; // [R7]
        end
    end

    // ==========================================================
    // Per-channel short protection and bridge drive

    // Modulator levels; in parallel the second stage copies channel one.
    assign lvl[0] = ch1_level;
    assign lvl[1] = parallel ? ch1_level : ch2_level; // [R12]

    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_ch
            reg [1:0] state;
            reg [15:0] timer;
            wire active;
            wire cmp_a;
            wire cmp_b;

            // Channel state flags seen by the start logic and the status word.
            assign ch_run[i] = (state == ST_RUN);
            assign ch_win[i] = (state == ST_WIN);
            // In parallel both stages stop together.
            assign active = started & go & (parallel ? (ch_run == 2'b11) : ch_run[i]); // [R12]
            // Carrier compares of the phase counter against the level.
            assign cmp_a = (cnt < lvl[i]);
            assign cmp_b = (cnt <= ~lvl[i]);

            // Short shutdown, timed retry and supply-short window hold.
            always @(posedge aclk) begin
                if (!aresetn) begin
                    state <= ST_RUN;
                    timer <= 16'h0000;
                end else begin
                    case (state)
                        ST_RUN: begin
                            if (load_short[i] || supply_short[i]) begin
                                state <= ST_OFF; // [R18]
                                timer <= 16'h0000;
                            end
                        end
                        ST_OFF: begin
                            if (ptick) begin
                                timer <= timer + 16'h0001; // [R22]
                                if (timer == RESTART_PERIODS[15:0] - 16'h0001) begin
                                    timer <= 16'h0000;
                                    if (supply_short[i]) begin
                                        state <= ST_WIN; // [R20]
                                    end else begin
                                        state <= ST_RUN; // [R19]
                                    end
                                end
                            end
                        end
                        ST_WIN: begin
                            if (!supply_short[i]) begin
                                state <= ST_RUN; // [R20]
                            end
                        end
                        default: state <= ST_RUN;
                    endcase
                end
            end

            // Bridge halves: complementary or in phase with inverted input.
            always @(posedge aclk) begin
                if (!aresetn) begin
                    bridge_p[i] <= 1'b0;
                    bridge_n[i] <= 1'b0;
                    current_limit[i] <= 1'b0;
                end else begin
                    current_limit[i] <= overcurrent_guard[i] & active; // [R17]
                    if (!active) begin
                        bridge_p[i] <= 1'b0; // [R16] [R18]
                        bridge_n[i] <= 1'b0;
                    end else if (in_phase) begin
                        bridge_p[i] <= cmp_a; // [R9]
                        bridge_n[i] <= cmp_b; // [R9]
                    end else begin
                        bridge_p[i] <= cmp_a; // [R8]
                        bridge_n[i] <= ~cmp_a; // [R8]
                    end
                end
            end
        end
    endgenerate

    // Gain foldback and clip detection enables.
    always @(posedge aclk) begin
        if (!aresetn) begin
            gain_reduce <= 1'b0;
            clip_detect_enable <= 2'b00;
        end else begin
            gain_reduce <= thermal_foldback & ~shutdown; // [R14]
            clip_detect_enable[0] <= ~ctrl[`CDMF_CTRL_CLIPOFF1]; // [R13]
            clip_detect_enable[1] <= ~ctrl[`CDMF_CTRL_CLIPOFF2]; // [R13]
        end
    end

    // ==========================================================
    // AXI4-Lite slave

    // Read-only status word gathered from live state.
    assign status = {14'h0, ch_win, ch_run, current_limit, shutdown,
                     gain_reduce, ops_code, started, in_phase, parallel,
                     host_ctrl, loop_on, spread_enable, is_master};

    // Address and data are taken together when no response is pending.
    assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_wready = s_axi_awready;
    assign s_axi_arready = ~s_axi_rvalid;

    // Write path: only the low byte of the control word holds bits.
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= `CDMF_CTRL_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
        end else if (s_axi_awready) begin
            s_axi_bvalid <= 1'b1;
            if (s_axi_awaddr == `CDMF_ADDR_CTRL) begin
                s_axi_bresp <= 2'b00;
                if (s_axi_wstrb[0]) begin
                    ctrl <= s_axi_wdata[5:0];
                end
            end else if (s_axi_awaddr == `CDMF_ADDR_STATUS) begin
                s_axi_bresp <= 2'b00;
            end else begin
                s_axi_bresp <= 2'b10;
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read path: unmapped addresses answer SLVERR with zero data.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'b00;
            case (s_axi_araddr)
                `CDMF_ADDR_CTRL: s_axi_rdata <= {26'h0, ctrl};
                `CDMF_ADDR_STATUS: s_axi_rdata <= status;
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

//--- inc/cdmf_map.vh
/*
 * Register map, field positions, strap codes and timing counts of the
 * class-D mode and fault control block.
 * Assumes a 10 MHz system clock and a 32-cycle switching period.
 */
`ifndef CDMF_MAP_VH
`define CDMF_MAP_VH

// ==========================================================
// Register byte addresses
`define CDMF_ADDR_CTRL 4'h0
`define CDMF_ADDR_STATUS 4'h4
`define CDMF_CTRL_RESET 6'h00

// ==========================================================
// Control register fields
`define CDMF_CTRL_INPHASE 0
`define CDMF_CTRL_SHIFT_LO 1
`define CDMF_CTRL_SHIFT_HI 3
`define CDMF_CTRL_CLIPOFF1 4
`define CDMF_CTRL_CLIPOFF2 5

// ==========================================================
// Operation-select strap levels, as reported by the comparators
`define CDMF_OPS_SHORT 3'h0
`define CDMF_OPS_4K7 3'h1
`define CDMF_OPS_13K 3'h2
`define CDMF_OPS_33K 3'h3
`define CDMF_OPS_100K 3'h4
`define CDMF_OPS_OPEN 3'h5

// ==========================================================
// Phase shift field codes and their offsets in switching-counter steps
`define CDMF_SEL_QUARTER 3'h0
`define CDMF_SEL_THIRD 3'h1
`define CDMF_SEL_HALF 3'h2
`define CDMF_SEL_TWO_THIRDS 3'h3
`define CDMF_SEL_THREE_QUARTERS 3'h4
`define CDMF_OFS_NONE 5'h00
`define CDMF_OFS_QUARTER 5'h04
`define CDMF_OFS_THIRD 5'h05
`define CDMF_OFS_HALF 5'h08
`define CDMF_OFS_TWO_THIRDS 5'h0b
`define CDMF_OFS_THREE_QUARTERS 5'h0c

// ==========================================================
// Timing
`define CDMF_CLK_KHZ 10000
`define CDMF_PWM_PERIOD 32
`define CDMF_RESTART_MS 50
`define CDMF_RESTART_PERIODS (`CDMF_RESTART_MS * `CDMF_CLK_KHZ / `CDMF_PWM_PERIOD)

`endif

//--- verif/cdmf_checker.sv
/*
 * Port checker for the class-D mode and fault control block.
 * Assumes it is bound to cdmf_top and sees only its ports.
 */
`timescale 1ns/10ps
// ==========================================================
// Checker
module cdmf_checker (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Straps and oscillator pin
    input wire logic oscillator_resistor_strap,
    input wire logic spread_loop_strap,
    input wire logic oscillator_clock_pin_in,
    input wire logic oscillator_clock_pin_oe,
    input wire logic spread_enable,
    input wire logic switch_clock,
    // Protection inputs
    input wire logic thermal_foldback,
    input wire logic thermal_trip,
    input wire logic overtemp,
    input wire logic [1:0] overcurrent_guard,
    input wire logic [1:0] load_short,
    input wire logic [1:0] supply_short,
    // Power stage outputs
    input wire logic gain_reduce,
    input wire logic [1:0] current_limit,
    input wire logic [1:0] bridge_p,
    input wire logic [1:0] bridge_n
);
    logic [1:0] ok = 2'h0;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Two edges out of reset before registered outputs are judged.
    always @(posedge aclk) begin
        ok <= {ok[0], aresetn};
    end
    osc_dir_a: assert property (&ok |-> oscillator_clock_pin_oe == $past(oscillator_resistor_strap))
        else $error("pin direction differs from strap");
    spread_on_a: assert property (&ok |->
        spread_enable == $past(oscillator_resistor_strap && spread_loop_strap))
        else $error("spread enable differs from straps");
    direct_clk_a: assert property (&ok && $past(!oscillator_resistor_strap && !spread_loop_strap)
        |-> switch_clock == $past(oscillator_clock_pin_in))
        else $error("switch clock not taken from pin");
    hot_stop_a: assert property (&ok && $past(overtemp) |-> bridge_p == 2'h0 && bridge_n == 2'h0)
        else $error("bridge drives during overtemperature");
    trip_stop_a: assert property (&ok && $past(thermal_foldback && thermal_trip)
        |-> !gain_reduce && bridge_p == 2'h0 && bridge_n == 2'h0)
        else $error("bridge drives after thermal trip");
    fold_gain_a: assert property (&ok && $past(thermal_foldback && !thermal_trip && !overtemp)
        |-> gain_reduce)
        else $error("gain not reduced in foldback");
    limit_src_a: assert property (&ok |-> (current_limit & ~$past(overcurrent_guard)) == 2'h0)
        else $error("current limit without guard");
    short_off_a: assert property (load_short[0] [*4] |-> bridge_p[0] == 1'h0 && bridge_n[0] == 1'h0)
        else $error("shorted channel still drives");
    window_a: assert property (supply_short[1] [*4] |-> bridge_p[1] == 1'h0 && bridge_n[1] == 1'h0)
        else $error("supply shorted channel drives");
    // Main scenarios reached.
    cover property (overtemp ##1 !overtemp);
    cover property (load_short[0] [*4]);
    cover property ($rose(gain_reduce));
endmodule
bind cdmf_top cdmf_checker u_chk (.*);

//--- verif/cdmf_clk_master.sv
/*
 * Clock-master model driving the shared oscillator pin.
 * Assumes run is high only while the block is a clock-slave.
 */
`timescale 1ns/10ps
// ==========================================================
// Model
module cdmf_clk_master #(
    parameter int PERIOD = 32
) (
    // Clock, enable and pin
    input wire logic aclk,
    input wire logic run,
    output logic osc
);
    int cnt = 0;
    initial osc = 1'h0;
    // Square wave of one switching period; stands low while stopped.
    always @(posedge aclk) begin
        cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
        osc <= run && (cnt < PERIOD / 2);
    end
endmodule

//--- verif/tb.sv
/*
 * Self-checking bench for the class-D mode and fault control block.
 * Assumes the checker binds itself and a clock-master model feeds the pin.
 */
`timescale 1ns/10ps
// ==========================================================
// Bench
module tb;
    localparam int RP = 4;
    logic aclk = 1'h0, aresetn = 1'h0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_wstrb = 4'hf, s_axi_araddr = 4'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic oscillator_resistor_strap = 1'h1, spread_loop_strap = 1'h0;
    logic bus_address_strap = 1'h0, amp_enable = 1'h0;
    logic [2:0] operation_select_strap = 3'h0;
    logic thermal_foldback = 1'h0, thermal_trip = 1'h0, overtemp = 1'h0;
    logic [4:0] ch1_level = 5'h10, ch2_level = 5'h10;
    logic [1:0] overcurrent_guard = 2'h0, load_short = 2'h0, supply_short = 2'h0;
    wire s_axi_awready, s_axi_wready, s_axi_arready, s_axi_bvalid, s_axi_rvalid;
    wire oscillator_clock_pin_out, oscillator_clock_pin_oe, oscillator_clock_pin_in;
    wire gain_reduce, switch_clock, spread_enable, ext_clk;
    wire [1:0] s_axi_bresp, s_axi_rresp, bridge_p, bridge_n, current_limit, clip_detect_enable;
    wire [31:0] s_axi_rdata;
    int errors = 0, checks = 0;
    // The pin level comes from whichever side drives it.
    assign oscillator_clock_pin_in = oscillator_clock_pin_oe ? oscillator_clock_pin_out : ext_clk;
    cdmf_top #(.RESTART_PERIODS(RP)) u_dut (.*);
    cdmf_clk_master u_osc (.aclk(aclk), .run(!oscillator_resistor_strap), .osc(ext_clk));
    // Clock of 100 ns.
    initial forever #50 aclk = ~aclk;
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task results;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do @(posedge aclk); while (s_axi_awready !== 1'h1);
        s_axi_awvalid <= 1'h0;
        s_axi_wvalid <= 1'h0;
        do @(posedge aclk); while (s_axi_bvalid !== 1'h1);
        s_axi_bready <= 1'h0;
    endtask
    task rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask
    // Cycles from a pin rise to the next fall of the switching clock.
    task meas(output int n);
        repeat (70) @(posedge aclk);
        while (oscillator_clock_pin_in !== 1'h0) @(posedge aclk);
        while (oscillator_clock_pin_in !== 1'h1) @(posedge aclk);
        n = 0;
        while (switch_clock !== 1'h1) begin
            @(posedge aclk);
            n++;
        end
        while (switch_clock !== 1'h0) begin
            @(posedge aclk);
            n++;
        end
    endtask
    // Which channels drove their bridge during one period.
    task act(output logic [1:0] a);
        a = 2'h0;
        repeat (33) begin
            @(posedge aclk);
            a = a | bridge_p | bridge_n;
        end
    endtask
    task pause;
        amp_enable <= 1'h0;
        repeat (3) @(posedge aclk);
    endtask
    task t_bus;
        logic [31:0] d;
        logic [1:0] r;
        spread_loop_strap <= 1'h1;
        wr(4'h0, 32'h30);
        rd(4'h0, d, r);
        chk("ctrl", d, 32'h30);
        chk("clip enables", clip_detect_enable, 2'h0);
        rd(4'h8, d, r);
        chk("unmapped resp", r, 2'h2);
        rd(4'h4, d, r);
        chk("osc mode bits", d[2:0], 3'h3);
        chk("spread out", spread_enable, 1'h1);
    endtask
    task t_strap;
        int n0, n;
        logic [1:0] a;
        @(posedge aclk);
        oscillator_resistor_strap <= 1'h0;
        spread_loop_strap <= 1'h1;
        for (int c = 0; c < 6; c++) begin
            operation_select_strap <= 3'(c);
            amp_enable <= 1'h1;
            meas(n);
            if (c == 0) n0 = n;
            chk("strap shift", n, n0 - ((c == 2 || c == 3) ? 8 : 0));
            operation_select_strap <= 3'(c ^ 1);
            act(a);
            chk("halves", {28'h0, a, bridge_p ^ bridge_n}, (c % 2) ? 32'hc : 32'hf);
            pause;
        end
        chk("pin dir", oscillator_clock_pin_oe, 1'h0);
        spread_loop_strap <= 1'h0;
        operation_select_strap <= 3'h0;
        amp_enable <= 1'h1;
        meas(n0);
        pause;
        operation_select_strap <= 3'h2;
        amp_enable <= 1'h1;
        meas(n);
        chk("no stagger", n, n0);
        pause;
    endtask
    task t_host;
        int n0, n;
        int ofs[5] = '{4, 5, 8, 11, 12};
        logic bad;
        bus_address_strap <= 1'h1;
        spread_loop_strap <= 1'h1;
        operation_select_strap <= 3'h0;
        wr(4'h0, 32'ha);
        amp_enable <= 1'h1;
        meas(n0);
        for (int s = 0; s < 5; s++) begin
            wr(4'h0, 32'(s * 2 + s % 2));
            meas(n);
            chk("host shift", n, n0 - ofs[s]);
            chk("host halves", {30'h0, bridge_p ^ bridge_n}, (s % 2) ? 32'h0 : 32'h3);
        end
        pause;
        wr(4'h0, 32'h30);
        operation_select_strap <= 3'h4;
        ch2_level <= 5'h04;
        amp_enable <= 1'h1;
        repeat (40) @(posedge aclk);
        bad = 1'h0;
        repeat (32) begin
            @(posedge aclk);
            bad = bad | (bridge_p[1] !== bridge_p[0]) | (bridge_n[1] !== bridge_n[0]);
        end
        chk("parallel", bad, 1'h0);
        chk("parallel clip", clip_detect_enable, 2'h0);
        pause;
        ch2_level <= 5'h10;
        bus_address_strap <= 1'h0;
        operation_select_strap <= 3'h0;
    endtask
    task t_fault;
        logic [1:0] a;
        oscillator_resistor_strap <= 1'h1;
        spread_loop_strap <= 1'h0;
        amp_enable <= 1'h1;
        overcurrent_guard <= 2'h1;
        act(a);
        chk("limit", current_limit, 2'h1);
        chk("limit run", a, 2'h3);
        overcurrent_guard <= 2'h0;
        load_short <= 2'h1;
        repeat (4) @(posedge aclk);
        act(a);
        chk("load short", a, 2'h2);
        load_short <= 2'h0;
        repeat (RP * 32 + 40) @(posedge aclk);
        act(a);
        chk("retry", a, 2'h3);
        supply_short <= 2'h2;
        repeat (RP * 32 + 40) @(posedge aclk);
        act(a);
        chk("window hold", a, 2'h1);
        supply_short <= 2'h0;
        act(a);
        act(a);
        chk("window free", a, 2'h3);
        thermal_foldback <= 1'h1;
        act(a);
        chk("foldback", {a, gain_reduce}, 3'h7);
        thermal_trip <= 1'h1;
        repeat (3) @(posedge aclk);
        act(a);
        chk("trip", {a, gain_reduce}, 3'h0);
        thermal_trip <= 1'h0;
        thermal_foldback <= 1'h0;
        overtemp <= 1'h1;
        repeat (3) @(posedge aclk);
        act(a);
        chk("overtemp", a, 2'h0);
        overtemp <= 1'h0;
    endtask
    // Main sequence.
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        t_bus;
        t_strap;
        t_host;
        t_fault;
        results;
    end
    // A hang counts as a mismatch.
    initial begin
        #3000000;
        errors++;
        results;
    end
endmodule
